// ### pkg/boot_seq_pkg.sv
// Functional notes
// RULE_01 - while reset is held, every state goes to its reset value; the strap synchronizers keep following the pins
// RULE_02 - on reset release, run the boot mode and configuration that were selected
// RULE_03 - host boot keeps the core stalled while the rest of the device runs
// RULE_04 - host may set up any memory or register through the host port
// RULE_05 - host ends the boot by setting the host-to-core interrupt bit
// RULE_06 - that bit in host boot ends the stall; core starts at address 0
// RULE_07 - an interrupt raised while the core is stalled is not passed on
// RULE_08 - the bit releases the stall only in host boot mode
// RULE_09 - host may write and read all memory during host boot
// RULE_10 - core must clear the bit; until then no new interrupt is taken
// RULE_11 - external boot copies 1 KB from chip-enable space one to address 0
// RULE_12 - ROM bytes are packed four at a time into 32-bit words
// RULE_13 - ROM image is stored in the system's configured byte order
// RULE_14 - copy runs as one block transfer with no core involvement
// RULE_15 - end of the copy releases the stall; core starts at address 0
// RULE_16 - no-boot mode runs from address 0 at once, no stall, no copy
// RULE_17 - in no-boot mode the system must place valid code at address 0
// RULE_18 - the two-bit mode select is sampled once at reset release
// RULE_19 - stall holds from reset to its release and never returns before reset
package boot_seq_pkg;

  typedef enum logic [1:0] {
    MODE_HOST,
    MODE_EXT_MEM,
    MODE_NONE
  } boot_mode_t;

  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_HOST_WAIT,
    ST_COPY,
    ST_RUN
  } seq_state_t;

  // default strap encodings, overridable at the top level
  localparam logic [1:0] SEL_NONE_DEF = 2'h0;
  localparam logic [1:0] SEL_HOST_DEF = 2'h1;
  localparam logic [1:0] SEL_EXT_DEF = 2'h2;

  localparam logic [10:0] IMAGE_BYTES = 11'h400;
  localparam logic [31:0] ROM_BASE = 32'h9000_0000;
  localparam logic [31:0] INT_BASE = 32'h0000_0000;
  localparam logic [31:0] BOOT_PC = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] LAST_LANE = 2'h3;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } rom_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic [31:0] word;
    logic [1:0] lane;
    logic valid;
  } packer_state_t;

  typedef struct packed {
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic end_meta;
    logic end_sync;
    seq_state_t state;
    boot_mode_t mode;
    logic big_endian;
    logic stall;
    logic periph;
    logic host_mem;
    logic flag;
    logic core_int;
    logic rom_timing;
    logic done;
    logic wr_pend;
    logic [10:0] byte_cnt;
    rom_req_t rom;
    mem_wr_t mem;
    logic [31:0] pc;
  } seq_state_s_t;

endpackage : boot_seq_pkg

// ### rtl/byte_packer.sv
module byte_packer
  import boot_seq_pkg::*;
(
  input wire logic clk_i, // device clock
  input wire logic reset_i, // synchronous reset
  input wire logic byte_valid_i, // one ROM byte accepted
  input wire logic [7:0] byte_i, // ROM byte
  input wire logic big_endian_i, // system byte order
  output logic word_valid_o, // one-cycle word pulse
  output logic [31:0] word_o // assembled word
);

  packer_state_t q_ff;
  packer_state_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.valid = 1'b0;
    if (byte_valid_i) begin
      // first byte lands at the far end, so order follows the straps
      if (big_endian_i) begin // RULE_13
        nxt_q.word = {q_ff.word[23:0], byte_i};
      end else begin
        nxt_q.word = {byte_i, q_ff.word[31:8]};
      end
      nxt_q.lane = q_ff.lane + 2'h1;
      nxt_q.valid = (q_ff.lane == LAST_LANE); // RULE_12
    end
    if (reset_i) begin
      nxt_q = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    q_ff <= nxt_q;
  end

  assign word_valid_o = q_ff.valid;
  assign word_o = q_ff.word;

endmodule : byte_packer

// ### rtl/boot_mode_sequencer.sv
module boot_mode_sequencer
  import boot_seq_pkg::*;
#(
  parameter logic [1:0] SEL_HOST = SEL_HOST_DEF,
  parameter logic [1:0] SEL_EXT = SEL_EXT_DEF,
  parameter logic [1:0] SEL_NONE = SEL_NONE_DEF
) (
  input wire logic clk_i, // device clock, 25 MHz
  input wire logic reset_i, // synchronous reset, active high
  input wire logic [1:0] boot_sel_i, // boot mode strap pins
  input wire logic big_endian_i, // byte order strap pin
  input wire logic host_ctl_wr_i, // host writes host_port_control
  input wire logic host_int_bit_i, // written host_to_core_interrupt value
  input wire logic core_int_clr_i, // core clears the interrupt bit
  input wire logic rom_rd_valid_i, // ROM byte returned
  input wire logic [7:0] rom_rd_data_i, // ROM byte data
  input wire logic mem_wr_ready_i, // internal memory takes the word
  output logic core_stall_o, // core held stalled
  output logic [31:0] core_start_pc_o, // fetch address after release
  output logic periph_release_o, // rest of device running
  output logic host_mem_en_o, // host may read and write all memory
  output logic host_to_core_interrupt_o, // interrupt bit state
  output logic core_int_o, // interrupt pulse to core
  output logic rom_timing_default_o, // memory interface uses default ROM timing
  output rom_req_t rom_req_o, // ROM byte read request
  output mem_wr_t mem_wr_o, // internal memory word write
  output boot_mode_t boot_mode_o, // decoded boot mode
  output logic boot_done_o // boot finished, core running
);

  seq_state_s_t q_ff;
  seq_state_s_t nxt_q;
  logic pk_valid;
  logic [31:0] pk_word;
  logic byte_take;
  logic host_set;
  logic host_accept;

  assign byte_take = q_ff.rom.valid && rom_rd_valid_i;
  assign host_set = host_ctl_wr_i && host_int_bit_i;
  assign host_accept = host_set && !q_ff.flag; // RULE_10

  byte_packer u_packer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .byte_valid_i(byte_take),
    .byte_i(rom_rd_data_i),
    .big_endian_i(q_ff.big_endian),
    .word_valid_o(pk_valid),
    .word_o(pk_word)
  );

  always_comb begin
    nxt_q = q_ff;
    // straps follow the pins even in reset so they are settled at release
    nxt_q.sel_meta = boot_sel_i;
    nxt_q.sel_sync = q_ff.sel_meta;
    nxt_q.end_meta = big_endian_i;
    nxt_q.end_sync = q_ff.end_meta;
    nxt_q.core_int = 1'b0;
    // set wins over clear; a set while the bit is up is not accepted
    nxt_q.flag = host_set || (q_ff.flag && !core_int_clr_i); // RULE_10
    nxt_q.core_int = host_accept && !q_ff.stall; // RULE_07

    case (q_ff.state)
      ST_SAMPLE: begin
        nxt_q.big_endian = q_ff.end_sync; // RULE_02
        nxt_q.periph = 1'b1; // RULE_03
        if (q_ff.sel_sync == SEL_EXT) begin // RULE_18
          nxt_q.mode = MODE_EXT_MEM;
          nxt_q.rom_timing = 1'b1; // RULE_11
          nxt_q.state = ST_COPY;
        end else if (q_ff.sel_sync == SEL_NONE) begin
          nxt_q.mode = MODE_NONE;
          nxt_q.stall = 1'b0; // RULE_16
          nxt_q.done = 1'b1;
          nxt_q.state = ST_RUN;
        end else begin
          // unknown codes fall back to host boot: the core stays safely held
          nxt_q.mode = MODE_HOST;
          nxt_q.host_mem = 1'b1; // RULE_09
          nxt_q.state = ST_HOST_WAIT;
        end
      end
      ST_HOST_WAIT: begin
        // a set that landed in the sample cycle must still end the stall
        if (host_accept || q_ff.flag) begin // RULE_06
          nxt_q.stall = 1'b0;
          nxt_q.done = 1'b1;
          nxt_q.state = ST_RUN;
        end
      end
      ST_COPY: begin // RULE_08
        // host writes are ignored here; only the copy ends the stall
        if (byte_take) begin // RULE_14
          nxt_q.rom.valid = 1'b0;
          nxt_q.byte_cnt = q_ff.byte_cnt + 11'h1;
          nxt_q.wr_pend = (q_ff.byte_cnt[1:0] == LAST_LANE);
        end else if (!q_ff.rom.valid && !q_ff.wr_pend && q_ff.byte_cnt != IMAGE_BYTES) begin
          nxt_q.rom.valid = 1'b1; // RULE_11
          nxt_q.rom.addr = ROM_BASE + {21'h0, q_ff.byte_cnt};
        end
        if (pk_valid) begin // RULE_12
          nxt_q.mem.valid = 1'b1;
          nxt_q.mem.data = pk_word;
        end
        if (q_ff.mem.valid && mem_wr_ready_i) begin
          nxt_q.mem.valid = 1'b0;
          nxt_q.mem.addr = q_ff.mem.addr + WORD_STEP;
          nxt_q.wr_pend = 1'b0;
        end
        if (q_ff.byte_cnt == IMAGE_BYTES && !q_ff.wr_pend) begin // RULE_15
          nxt_q.stall = 1'b0;
          nxt_q.rom_timing = 1'b0;
          nxt_q.done = 1'b1;
          nxt_q.state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_q.stall = 1'b0; // RULE_19
      end
      default: begin
        nxt_q.state = ST_RUN;
      end
    endcase

    if (reset_i) begin // RULE_01
      nxt_q.state = ST_SAMPLE;
      nxt_q.mode = MODE_HOST;
      nxt_q.big_endian = 1'b0;
      nxt_q.stall = 1'b1; // RULE_19
      nxt_q.periph = 1'b0;
      nxt_q.host_mem = 1'b0;
      nxt_q.flag = 1'b0;
      nxt_q.core_int = 1'b0;
      nxt_q.rom_timing = 1'b0;
      nxt_q.done = 1'b0;
      nxt_q.wr_pend = 1'b0;
      nxt_q.byte_cnt = '0;
      nxt_q.rom = '0;
      nxt_q.mem = '0;
      nxt_q.mem.addr = INT_BASE;
      nxt_q.pc = BOOT_PC;
    end
  end

  always_ff @(posedge clk_i) begin
    q_ff <= nxt_q;
  end

  assign core_stall_o = q_ff.stall;
  assign core_start_pc_o = q_ff.pc;
  assign periph_release_o = q_ff.periph;
  assign host_mem_en_o = q_ff.host_mem;
  assign host_to_core_interrupt_o = q_ff.flag;
  assign core_int_o = q_ff.core_int;
  assign rom_timing_default_o = q_ff.rom_timing;
  assign rom_req_o = q_ff.rom;
  assign mem_wr_o = q_ff.mem;
  assign boot_mode_o = q_ff.mode;
  assign boot_done_o = q_ff.done;

  // checks

  property p_reset_state;
    @(posedge clk_i)
    reset_i |=> core_stall_o && !periph_release_o && !core_int_o && !mem_wr_o.valid
      && !host_to_core_interrupt_o;
  endproperty
  a_reset_state: assert property (p_reset_state) // RULE_01
    else $error("state not at reset value during reset");

  property p_periph_release;
    @(posedge clk_i) disable iff (reset_i)
    $fell(reset_i) |=> periph_release_o;
  endproperty
  a_periph_release: assert property (p_periph_release) // RULE_03
    else $error("rest of device not released after reset");

  property p_no_boot_run;
    @(posedge clk_i) disable iff (reset_i)
    ($fell(reset_i) && q_ff.sel_sync == SEL_NONE) |=> !core_stall_o && core_start_pc_o == BOOT_PC
      && boot_mode_o == MODE_NONE;
  endproperty
  a_no_boot_run: assert property (p_no_boot_run) // RULE_16
    else $error("no-boot mode did not run at once");

  property p_host_release;
    @(posedge clk_i) disable iff (reset_i)
    (q_ff.state == ST_HOST_WAIT && host_set && !host_to_core_interrupt_o)
      |=> !core_stall_o && boot_done_o && core_start_pc_o == BOOT_PC;
  endproperty
  a_host_release: assert property (p_host_release) // RULE_06
    else $error("host interrupt bit did not end the stall");

  property p_no_int_stalled;
    @(posedge clk_i) disable iff (reset_i)
    core_int_o |-> !$past(core_stall_o);
  endproperty
  a_no_int_stalled: assert property (p_no_int_stalled) // RULE_07
    else $error("interrupt passed to a stalled core");

  property p_copy_ignores_host;
    @(posedge clk_i) disable iff (reset_i)
    (q_ff.state == ST_COPY && q_ff.byte_cnt != IMAGE_BYTES && host_set) |=> core_stall_o;
  endproperty
  a_copy_ignores_host: assert property (p_copy_ignores_host) // RULE_08
    else $error("host interrupt released stall outside host boot");

  property p_host_mem;
    @(posedge clk_i) disable iff (reset_i)
    (q_ff.state == ST_HOST_WAIT) |-> host_mem_en_o && core_stall_o;
  endproperty
  a_host_mem: assert property (p_host_mem) // RULE_09
    else $error("host memory access not open during host boot");

  property p_flag_blocks;
    @(posedge clk_i) disable iff (reset_i)
    (host_to_core_interrupt_o && host_set) |=> host_to_core_interrupt_o && !core_int_o;
  endproperty
  a_flag_blocks: assert property (p_flag_blocks) // RULE_10
    else $error("interrupt accepted while bit still set");

  property p_rom_addr;
    @(posedge clk_i) disable iff (reset_i)
    rom_req_o.valid |-> rom_timing_default_o && core_stall_o
      && rom_req_o.addr == ROM_BASE + {21'h0, q_ff.byte_cnt};
  endproperty
  a_rom_addr: assert property (p_rom_addr) // RULE_11
    else $error("ROM read outside the boot image");

  property p_word_hold;
    @(posedge clk_i) disable iff (reset_i)
    (mem_wr_o.valid && !mem_wr_ready_i) |=> mem_wr_o.valid && $stable(mem_wr_o.data)
      && $stable(mem_wr_o.addr);
  endproperty
  a_word_hold: assert property (p_word_hold) // RULE_12
    else $error("packed word dropped before it was taken");

  property p_copy_complete;
    @(posedge clk_i) disable iff (reset_i)
    ($fell(core_stall_o) && boot_mode_o == MODE_EXT_MEM) |-> q_ff.byte_cnt == IMAGE_BYTES
      && mem_wr_o.addr == INT_BASE + {21'h0, IMAGE_BYTES};
  endproperty
  a_copy_complete: assert property (p_copy_complete) // RULE_15
    else $error("stall released before the image was copied");

  property p_never_restall;
    @(posedge clk_i) disable iff (reset_i)
    !core_stall_o |=> !core_stall_o;
  endproperty
  a_never_restall: assert property (p_never_restall) // RULE_19
    else $error("core stall reasserted without reset");

  property p_mode_held;
    @(posedge clk_i) disable iff (reset_i)
    (q_ff.state != ST_SAMPLE) |=> $stable(boot_mode_o) && $stable(q_ff.big_endian);
  endproperty
  a_mode_held: assert property (p_mode_held) // RULE_18
    else $error("boot mode changed after it was sampled");

  property p_early_release;
    @(posedge clk_i) disable iff (reset_i)
    (q_ff.state == ST_HOST_WAIT && host_to_core_interrupt_o) |=> !core_stall_o;
  endproperty
  a_early_release: assert property (p_early_release) // RULE_06
    else $error("bit set before host wait did not end the stall");

  property p_rom_timing;
    @(posedge clk_i) disable iff (reset_i)
    rom_timing_default_o |-> boot_mode_o == MODE_EXT_MEM && core_stall_o;
  endproperty
  a_rom_timing: assert property (p_rom_timing) // RULE_11
    else $error("default ROM timing outside the boot copy");

  property p_no_read_pending;
    @(posedge clk_i) disable iff (reset_i)
    mem_wr_o.valid |-> !rom_req_o.valid;
  endproperty
  a_no_read_pending: assert property (p_no_read_pending) // RULE_12
    else $error("ROM read issued while a packed word waits");

  property p_word_range;
    @(posedge clk_i) disable iff (reset_i)
    mem_wr_o.valid |-> mem_wr_o.addr[1:0] == 2'h0
      && mem_wr_o.addr < INT_BASE + {21'h0, IMAGE_BYTES};
  endproperty
  a_word_range: assert property (p_word_range) // RULE_11
    else $error("word written outside the boot image area");

  property p_done_running;
    @(posedge clk_i) disable iff (reset_i)
    boot_done_o |-> !core_stall_o;
  endproperty
  a_done_running: assert property (p_done_running) // RULE_19
    else $error("boot finished but core still stalled");

  c_host_boot: cover property (@(posedge clk_i) disable iff (reset_i)
    boot_mode_o == MODE_HOST && $fell(core_stall_o));
  c_copy_boot: cover property (@(posedge clk_i) disable iff (reset_i)
    boot_mode_o == MODE_EXT_MEM && $fell(core_stall_o));
  c_no_boot: cover property (@(posedge clk_i) disable iff (reset_i)
    boot_mode_o == MODE_NONE && boot_done_o);
  c_core_int: cover property (@(posedge clk_i) disable iff (reset_i) core_int_o);
  c_early_set: cover property (@(posedge clk_i) disable iff (reset_i)
    q_ff.state == ST_HOST_WAIT && host_to_core_interrupt_o);

endmodule : boot_mode_sequencer

// ### sim/boot_far_side_model.sv
module boot_far_side_model
  import boot_seq_pkg::*;
(
  input wire logic clk_i, // device clock
  input wire logic slow_i, // stretch every ROM answer, toggle write ready
  input rom_req_t rom_req_i, // byte read request
  output logic rom_rd_valid_o, // byte returned
  output logic [7:0] rom_rd_data_o, // byte value
  output logic mem_wr_ready_o // word taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  logic [9:0] off;
  assign off = rom_req_i.addr[9:0];
  initial begin
    rom_rd_valid_o = 1'b0;
    rom_rd_data_o = 8'h00;
    mem_wr_ready_o = 1'b1;
    wait_ff = 2'h0;
  end
  // image laid out in the system byte order: value depends on offset only
  always @(posedge clk_i) begin
    rom_rd_valid_o <= 1'b0;
    rom_rd_data_o <= ~rom_rd_data_o; // released bus never repeats the last byte
    mem_wr_ready_o <= slow_i ? ~mem_wr_ready_o : 1'b1;
    if (rom_req_i.valid && !rom_rd_valid_o) begin
      if (wait_ff == (slow_i ? 2'h2 : 2'h0)) begin
        rom_rd_valid_o <= 1'b1;
        rom_rd_data_o <= off[7:0] + {off[9:8], 6'h05};
        wait_ff <= 2'h0;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule : boot_far_side_model

// ### sim/test_boot_mode_sequencer.sv
module test_boot_mode_sequencer;
  import boot_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, big_endian_i, host_ctl_wr_i, host_int_bit_i, core_int_clr_i;
  logic rom_rd_valid_i, mem_wr_ready_i, slow, be_ff, stall_bad;
  logic [1:0] boot_sel_i;
  logic [7:0] rom_rd_data_i;
  logic core_stall_o, periph_release_o, host_mem_en_o, host_to_core_interrupt_o;
  logic core_int_o, rom_timing_default_o, boot_done_o;
  logic [31:0] core_start_pc_o;
  rom_req_t rom_req_o;
  mem_wr_t mem_wr_o;
  boot_mode_t boot_mode_o;
  int err_total, n_checks, n_int, wcnt, cyc;

  boot_mode_sequencer dut (.clk_i(clk_i), .reset_i(reset_i), .boot_sel_i(boot_sel_i),
    .big_endian_i(big_endian_i), .host_ctl_wr_i(host_ctl_wr_i),
    .host_int_bit_i(host_int_bit_i), .core_int_clr_i(core_int_clr_i),
    .rom_rd_valid_i(rom_rd_valid_i), .rom_rd_data_i(rom_rd_data_i),
    .mem_wr_ready_i(mem_wr_ready_i), .core_stall_o(core_stall_o),
    .core_start_pc_o(core_start_pc_o), .periph_release_o(periph_release_o),
    .host_mem_en_o(host_mem_en_o), .host_to_core_interrupt_o(host_to_core_interrupt_o),
    .core_int_o(core_int_o), .rom_timing_default_o(rom_timing_default_o),
    .rom_req_o(rom_req_o), .mem_wr_o(mem_wr_o), .boot_mode_o(boot_mode_o),
    .boot_done_o(boot_done_o));
  boot_far_side_model far (.clk_i(clk_i), .slow_i(slow), .rom_req_i(rom_req_o),
    .rom_rd_valid_o(rom_rd_valid_i), .rom_rd_data_o(rom_rd_data_i),
    .mem_wr_ready_o(mem_wr_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [7:0] rb(int a);
    return a[7:0] + {a[9:8], 6'h05};
  endfunction : rb

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // every word written must be the next one of the image, packed in the strap order
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      $display("[ERR] run length expected below 60000 seen 60000");
      final_report();
    end
    if (core_int_o === 1'b1) n_int++;
    if (mem_wr_o.valid === 1'b1 && mem_wr_ready_i) begin
      chk("word address", 32'(wcnt * 4), mem_wr_o.addr);
      chk("word data", be_ff ? {rb(4*wcnt), rb(4*wcnt+1), rb(4*wcnt+2), rb(4*wcnt+3)}
        : {rb(4*wcnt+3), rb(4*wcnt+2), rb(4*wcnt+1), rb(4*wcnt)}, mem_wr_o.data);
      wcnt++;
    end
  end

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic do_reset(logic [1:0] sel, logic be, logic sl);
    boot_sel_i = sel;
    big_endian_i = be;
    be_ff = be;
    slow = sl;
    reset_i = 1'b1;
    repeat (4) tick();
    chk("stall in reset", 1, core_stall_o);
    chk("done in reset", 0, boot_done_o);
    chk("bit in reset", 0, host_to_core_interrupt_o);
    wcnt = 0;
    reset_i = 1'b0;
    repeat (3) tick();
  endtask : do_reset

  task automatic host_set();
    host_ctl_wr_i = 1'b1;
    host_int_bit_i = 1'b1;
    tick();
    host_ctl_wr_i = 1'b0;
    host_int_bit_i = 1'b0;
    tick();
  endtask : host_set

  task automatic no_boot();
    do_reset(SEL_NONE_DEF, 1'b0, 1'b0);
    boot_sel_i = SEL_HOST_DEF;
    tick();
    chk("mode", MODE_NONE, boot_mode_o);
    chk("stall", 0, core_stall_o);
    chk("done", 1, boot_done_o);
    chk("pc", BOOT_PC, core_start_pc_o);
    chk("rom read", 0, rom_req_o.valid);
    host_set();
    chk("stall after set", 0, core_stall_o);
  endtask : no_boot

  task automatic host_boot();
    int base;
    do_reset(SEL_HOST_DEF, 1'b0, 1'b0);
    chk("mode", MODE_HOST, boot_mode_o);
    chk("periph", 1, periph_release_o);
    chk("host mem", 1, host_mem_en_o);
    repeat (20) tick();
    chk("stall held", 1, core_stall_o);
    base = n_int;
    host_set();
    chk("bit set", 1, host_to_core_interrupt_o);
    chk("stall released", 0, core_stall_o);
    chk("done", 1, boot_done_o);
    chk("pc", BOOT_PC, core_start_pc_o);
    repeat (3) tick();
    chk("pulses after stall set", base, n_int);
    host_set();
    chk("pulses while bit held", base, n_int);
    core_int_clr_i = 1'b1;
    tick();
    core_int_clr_i = 1'b0;
    tick();
    chk("bit cleared", 0, host_to_core_interrupt_o);
    host_set();
    tick();
    chk("pulses after clear", base + 1, n_int);
    chk("stall stays low", 0, core_stall_o);
    chk("host mem kept", 1, host_mem_en_o);
  endtask : host_boot

  // unused strap code falls back to host boot; host sets the bit in the sample cycle
  task automatic odd_code();
    boot_sel_i = 2'h3;
    reset_i = 1'b1;
    repeat (4) tick();
    reset_i = 1'b0;
    host_ctl_wr_i = 1'b1;
    host_int_bit_i = 1'b1;
    tick();
    host_ctl_wr_i = 1'b0;
    host_int_bit_i = 1'b0;
    tick();
    chk("odd code mode", MODE_HOST, boot_mode_o);
    chk("early set bit", 1, host_to_core_interrupt_o);
    chk("early set release", 0, core_stall_o);
    chk("early set done", 1, boot_done_o);
  endtask : odd_code

  task automatic ext_boot(logic be, logic sl);
    int base;
    do_reset(SEL_EXT_DEF, be, sl);
    stall_bad = 1'b0;
    chk("mode", MODE_EXT_MEM, boot_mode_o);
    chk("rom timing", 1, rom_timing_default_o);
    chk("rom base", ROM_BASE, rom_req_o.addr);
    repeat (50) tick();
    base = n_int;
    host_set();
    chk("stall after set", 1, core_stall_o);
    for (int i = 0; i < 20000 && boot_done_o !== 1'b1; i++) begin
      if (core_stall_o !== 1'b1) stall_bad = 1'b1;
      tick();
    end
    chk("stall through copy", 0, stall_bad);
    chk("words", 256, wcnt);
    chk("stall released", 0, core_stall_o);
    chk("pc", BOOT_PC, core_start_pc_o);
    chk("rom timing after", 0, rom_timing_default_o);
    chk("pulses in copy", base, n_int);
    repeat (4) tick();
    chk("words after end", 256, wcnt);
  endtask : ext_boot

  initial begin
    {reset_i, big_endian_i, host_ctl_wr_i, host_int_bit_i, core_int_clr_i} = 5'h10;
    {slow, be_ff} = 2'h0;
    boot_sel_i = 2'h0;
    {err_total, n_checks, n_int, wcnt, cyc} = '0;
    no_boot();
    host_boot();
    odd_code();
    ext_boot(1'b0, 1'b0);
    ext_boot(1'b1, 1'b1);
    final_report();
  end
endmodule : test_boot_mode_sequencer
